// File: logic/fpbu_pkg.sv
/*
 * Constants, register layout and carrier types of the flash patch and
 * breakpoint unit.
 * Assumes a 32-bit core address space whose top three bits select flash or RAM.
 */
package fpbu_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NUM_INSN = 6;
  localparam int NUM_LIT  = 2;
  localparam int NUM_COMP = NUM_INSN + NUM_LIT;

  // ***************************************************************
  // Register map (byte addresses on the register bus)
  // ***************************************************************
  localparam logic [5:0] OFF_CTRL   = 6'h00;
  localparam logic [5:0] OFF_REMAP  = 6'h04;
  localparam logic [5:0] OFF_STATUS = 6'h08;
  localparam logic [5:0] OFF_COMP0  = 6'h10;
  localparam logic [5:0] OFF_COMP7  = 6'h2C;

  // Field positions.
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_NINSN_LSB = 4;
  localparam int CTRL_NLIT_LSB  = 8;
  localparam int COMP_EN_BIT    = 0;
  localparam int COMP_BKPT_BIT  = 1;
  localparam int COMP_ADDR_LSB  = 2;
  localparam int COMP_ADDR_MSB  = 28;
  localparam int REMAP_LSB      = 5;
  localparam int REMAP_MSB      = 28;
  localparam int STAT_BKPT_BIT  = 3;
  localparam int STAT_HIT_BIT   = 4;

  // Reset values.
  localparam logic        CTRL_EN_RST = 1'b0;
  localparam logic [23:0] REMAP_RST   = 24'h000000;
  localparam logic [31:0] COMP_RST    = 32'h00000000;

  // ***************************************************************
  // Address regions
  // ***************************************************************
  localparam logic [2:0] FLASH_REGION = 3'h0;
  localparam logic [2:0] RAM_REGION   = 3'h1;

  // Breakpoint opcode handed to the core; the value is arbitrary.
  localparam logic [15:0] BKPT_INSN = 16'h0000;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic        valid;
    logic        literal;
    logic [31:0] addr;
  } fpbu_req_t;

  typedef struct packed {
    logic        flashValid;
    logic        literal;
    logic [31:0] flashAddr;
    logic [31:0] protAddr;
    logic        remapValid;
    logic [31:0] remapAddr;
    logic        bkptValid;
    logic [15:0] bkptInsn;
  } fpbu_rsp_t;

endpackage

// File: logic/fpbu_top.sv
/*
 * Flash patch and breakpoint unit: eight address comparators beside the
 * core fetch paths, configured over an Avalon-MM slave with waitrequest.
 * Assumes one fetch request per cycle from the core and a single clock.
 */
`timescale 1ns/1ps
module fpbu_top (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset,
  // Avalon-MM register slave
  input  wire logic [5:0]          avAddress,
  input  wire logic                avRead,
  input  wire logic                avWrite,
  input  wire logic [31:0]         avWriteData,
  input  wire logic [3:0]          avByteEnable,
  output      logic [31:0]         avReadData,
  output      logic                avWaitRequest,
  // Core fetch path
  input  wire fpbu_pkg::fpbu_req_t fetchReq,
  output      fpbu_pkg::fpbu_rsp_t fetchRsp
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic                globalEnReg,  globalEnNext;
  logic [23:0]         remapBaseReg, remapBaseNext;
  logic [31:0]         compReg  [fpbu_pkg::NUM_COMP];
  logic [31:0]         compNext [fpbu_pkg::NUM_COMP];
  logic                waitReg,      waitNext;
  logic [31:0]         rdataReg,     rdataNext;
  logic [2:0]          lastIdxReg,   lastIdxNext;
  logic                lastBkptReg,  lastBkptNext;
  logic                lastHitReg,   lastHitNext;
  fpbu_pkg::fpbu_rsp_t rspReg,       rspNext;
  logic [fpbu_pkg::NUM_COMP-1:0] hitVec;
  logic [fpbu_pkg::NUM_COMP-1:0] compEnVec;
  logic [2:0]          hitIdx;
  logic                hitAny;
  logic                inFlash;
  logic                litAligned;
  logic [31:0]         regView;
  logic [31:0]         remapWord;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ***************************************************************
  // Comparators
  // ***************************************************************
  assign inFlash    = fetchReq.addr[31:29] == fpbu_pkg::FLASH_REGION;
  assign litAligned = fetchReq.addr[1:0] == 2'h0;

  // Comparators 0 to 5 watch instruction fetches, 6 and 7 watch literal loads.
  for (genvar i = 0; i < fpbu_pkg::NUM_COMP; i++) begin : g_cmp
    logic kindOk;
    assign compEnVec[i] = compReg[i][fpbu_pkg::COMP_EN_BIT];
    if (i < fpbu_pkg::NUM_INSN) begin : g_insn
      assign kindOk = !fetchReq.literal;
    end else begin : g_lit
      assign kindOk = fetchReq.literal && litAligned;
    end
    assign hitVec[i] = fetchReq.valid && globalEnReg && compEnVec[i] && inFlash && kindOk
                       && fetchReq.addr[28:2] == compReg[i][fpbu_pkg::COMP_ADDR_MSB:fpbu_pkg::COMP_ADDR_LSB];
  end

  // Lowest index wins when several comparators hit.
  always_comb begin
    hitIdx = 3'h0;
    hitAny = 1'b0;
    for (int i = fpbu_pkg::NUM_COMP - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        hitIdx = 3'(i);
        hitAny = 1'b1;
      end
    end
  end

  // ***************************************************************
  // Fetch response
  // ***************************************************************
  // The match result leaves in the same cycle as the flash access it belongs
  // to; the core cannot cancel the flash access, so both are presented.
  always_comb begin
    rspNext            = '0;
    rspNext.flashValid = fetchReq.valid;
    rspNext.literal    = fetchReq.literal;
    rspNext.flashAddr  = fetchReq.addr;
    rspNext.protAddr   = fetchReq.addr;
    rspNext.bkptInsn   = fpbu_pkg::BKPT_INSN;
    if (hitAny) begin
      if (hitIdx < 3'(fpbu_pkg::NUM_INSN) && compReg[hitIdx][fpbu_pkg::COMP_BKPT_BIT]) begin
        rspNext.bkptValid = 1'b1;
      end else begin
        rspNext.remapValid = 1'b1;
        rspNext.remapAddr  = {fpbu_pkg::RAM_REGION, remapBaseReg, hitIdx, 2'h0};
      end
    end
    lastIdxNext  = hitAny ? hitIdx : lastIdxReg;
    lastBkptNext = hitAny ? rspNext.bkptValid : lastBkptReg;
    lastHitNext  = hitAny | lastHitReg;
  end

  // ***************************************************************
  // Register slave
  // ***************************************************************
  always_comb begin
    regView = 32'h00000000;
    unique case (avAddress)
      fpbu_pkg::OFF_CTRL: begin
        regView[fpbu_pkg::CTRL_EN_BIT] = globalEnReg;
        regView[fpbu_pkg::CTRL_NINSN_LSB +: 4] = 4'(fpbu_pkg::NUM_INSN);
        regView[fpbu_pkg::CTRL_NLIT_LSB +: 4]  = 4'(fpbu_pkg::NUM_LIT);
      end
      fpbu_pkg::OFF_REMAP: regView[fpbu_pkg::REMAP_MSB:fpbu_pkg::REMAP_LSB] = remapBaseReg;
      fpbu_pkg::OFF_STATUS: begin
        regView[2:0] = lastIdxReg;
        regView[fpbu_pkg::STAT_BKPT_BIT] = lastBkptReg;
        regView[fpbu_pkg::STAT_HIT_BIT]  = lastHitReg;
      end
      default: begin
        if (avAddress >= fpbu_pkg::OFF_COMP0 && avAddress <= fpbu_pkg::OFF_COMP7 && avAddress[1:0] == 2'h0) begin
          regView = compReg[3'(avAddress[5:2] - fpbu_pkg::OFF_COMP0[5:2])];
        end
      end
    endcase
  end

  // A request is held one cycle with waitrequest high, then completes with
  // waitrequest low; unmapped reads return zero and unmapped writes drop.
  // Byte lanes of the remap word are merged first, so only the base field is kept.
  assign remapWord = merge({3'h0, remapBaseReg, 5'h00}, avWriteData, avByteEnable);

  always_comb begin
    waitNext      = 1'b1;
    rdataNext     = rdataReg;
    globalEnNext  = globalEnReg;
    remapBaseNext = remapBaseReg;
    compNext      = compReg;
    if ((avRead || avWrite) && waitReg) begin
      waitNext  = 1'b0;
      rdataNext = avRead ? regView : 32'h00000000;
    end
    if (avWrite && !waitReg) begin
      unique case (avAddress)
        fpbu_pkg::OFF_CTRL: begin
          if (avByteEnable[0]) begin
            globalEnNext = avWriteData[fpbu_pkg::CTRL_EN_BIT];
          end
        end
        fpbu_pkg::OFF_REMAP: begin
          remapBaseNext = remapWord[fpbu_pkg::REMAP_MSB:fpbu_pkg::REMAP_LSB];
        end
        default: begin
          if (avAddress >= fpbu_pkg::OFF_COMP0 && avAddress <= fpbu_pkg::OFF_COMP7 && avAddress[1:0] == 2'h0) begin
            compNext[3'(avAddress[5:2] - fpbu_pkg::OFF_COMP0[5:2])] =
              merge(compReg[3'(avAddress[5:2] - fpbu_pkg::OFF_COMP0[5:2])], avWriteData, avByteEnable);
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      globalEnReg  <= fpbu_pkg::CTRL_EN_RST;
      remapBaseReg <= fpbu_pkg::REMAP_RST;
      for (int i = 0; i < fpbu_pkg::NUM_COMP; i++) begin
        compReg[i] <= fpbu_pkg::COMP_RST;
      end
      waitReg      <= 1'b1;
      rdataReg     <= 32'h00000000;
      rspReg       <= '0;
      lastIdxReg   <= 3'h0;
      lastBkptReg  <= 1'b0;
      lastHitReg   <= 1'b0;
    end else begin
      globalEnReg  <= globalEnNext;
      remapBaseReg <= remapBaseNext;
      compReg      <= compNext;
      waitReg      <= waitNext;
      rdataReg     <= rdataNext;
      rspReg       <= rspNext;
      lastIdxReg   <= lastIdxNext;
      lastBkptReg  <= lastBkptNext;
      lastHitReg   <= lastHitNext;
    end
  end

  assign avWaitRequest = waitReg;
  assign avReadData    = rdataReg;
  assign fetchRsp      = rspReg;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_busAnswer;
    !avWaitRequest ##1 avWaitRequest;
  endsequence
  sequence s_flashIssued;
    fetchRsp.flashValid && fetchRsp.flashAddr == $past(fetchReq.addr);
  endsequence

  property p_flashAlways;
    fetchReq.valid |=> s_flashIssued;
  endproperty
  a_flashAlways: assert property (p_flashAlways) else $error("flash access not issued");
  property p_protOrig;
    fetchRsp.flashValid |-> fetchRsp.protAddr == fetchRsp.flashAddr;
  endproperty
  a_protOrig: assert property (p_protOrig) else $error("protection address not original");
  property p_globalOff;
    fetchReq.valid && !globalEnReg |=> !fetchRsp.remapValid && !fetchRsp.bkptValid;
  endproperty
  a_globalOff: assert property (p_globalOff) else $error("action with global enable clear");
  property p_compOff;
    fetchReq.valid && compEnVec == '0 |=> !fetchRsp.remapValid && !fetchRsp.bkptValid;
  endproperty
  a_compOff: assert property (p_compOff) else $error("action with all comparators off");
  property p_unaligned;
    fetchReq.valid && fetchReq.literal && fetchReq.addr[1:0] != 2'h0 |=> !fetchRsp.remapValid;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned literal remapped");
  property p_litNoBkpt;
    fetchRsp.bkptValid |-> !fetchRsp.literal && !fetchRsp.remapValid;
  endproperty
  a_litNoBkpt: assert property (p_litNoBkpt) else $error("breakpoint on literal or with remap");
  property p_remapBase;
    fetchRsp.remapValid |-> fetchRsp.remapAddr[31:5] == {fpbu_pkg::RAM_REGION, $past(remapBaseReg)};
  endproperty
  a_remapBase: assert property (p_remapBase) else $error("remap address off base");
  property p_lowest;
    hitVec[0] |=> fetchRsp.bkptValid || fetchRsp.remapAddr[4:2] == 3'h0;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest comparator not chosen");
  property p_concurrent;
    fetchRsp.remapValid || fetchRsp.bkptValid |-> fetchRsp.flashValid;
  endproperty
  a_concurrent: assert property (p_concurrent) else $error("match apart from its access");
  property p_litHit;
    hitVec[7:6] != 2'h0 |=> fetchRsp.remapValid && fetchRsp.literal;
  endproperty
  a_litHit: assert property (p_litHit) else $error("literal hit not remapped");
  property p_insnHit;
    hitVec[5:0] != 6'h00 |=> (fetchRsp.remapValid || fetchRsp.bkptValid) && !fetchRsp.literal;
  endproperty
  a_insnHit: assert property (p_insnHit) else $error("instruction hit lost");
  property p_busAnswer;
    (avRead || avWrite) && avWaitRequest |=> s_busAnswer;
  endproperty
  a_busAnswer: assert property (p_busAnswer) else $error("bus answer not in one cycle");

endmodule

// File: verif/fpbu_core_model.sv
/*
 * Behavioural model of the core fetch side that faces the flash patch unit.
 * Assumes the bench hands it at most one request per cycle on cmd.
 */
`timescale 1ns/1ps
module fpbu_core_model (
  // Reset
  input  wire logic                reset,
  // Requests from the bench
  input  wire fpbu_pkg::fpbu_req_t cmd,
  // Fetch path to the unit
  output      fpbu_pkg::fpbu_req_t fetchReq,
  input  wire fpbu_pkg::fpbu_rsp_t fetchRsp,
  // Address whose data the core keeps
  output      logic [31:0]         usedAddr
);
  // ***************************************************************
  // Requests and data selection
  // ***************************************************************
  // No request may leave the core while reset is still applied.
  always_comb begin
    fetchReq = reset ? '0 : cmd;
  end

  // The flash word still arrives on a remap hit, so it must be dropped here.
  always_comb begin
    usedAddr = fetchRsp.remapValid ? fetchRsp.remapAddr : fetchRsp.flashAddr;
  end
endmodule

// File: verif/tb_top.sv
/*
 * Self-checking bench of the flash patch and breakpoint unit.
 * Assumes the package constants and the core fetch model beside this file.
 */
`timescale 1ns/1ps
module tb_top;
  localparam logic [23:0] BASE = 24'hA5C3F1;

  logic                core_clk;
  logic                reset;
  logic [5:0]          avAddress;
  logic                avRead;
  logic                avWrite;
  logic [31:0]         avWriteData;
  logic [3:0]          avByteEnable;
  logic [31:0]         avReadData;
  logic                avWaitRequest;
  fpbu_pkg::fpbu_req_t cmd;
  fpbu_pkg::fpbu_req_t fetchReq;
  fpbu_pkg::fpbu_rsp_t fetchRsp;
  logic [31:0]         usedAddr;
  int                  errTotal;
  int                  totalChecks;

  fpbu_top uut (.core_clk(core_clk), .reset(reset), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWriteData(avWriteData), .avByteEnable(avByteEnable),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest), .fetchReq(fetchReq), .fetchRsp(fetchRsp));

  fpbu_core_model core (.reset(reset), .cmd(cmd), .fetchReq(fetchReq), .fetchRsp(fetchRsp),
    .usedAddr(usedAddr));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic stopTest;
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] compVal(input logic [31:0] a, input logic bk, input logic en);
    return {3'h0, a[28:2], bk, en};
  endfunction

  function automatic logic [31:0] remapOf(input int i);
    return {3'h1, BASE, 3'(i), 2'h0};
  endfunction

  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic avXfer(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avAddress   <= a;
    avWrite     <= wr;
    avRead      <= !wr;
    avWriteData <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 50);
    q = avReadData;
    avRead  <= 1'b0;
    avWrite <= 1'b0;
    if (avWaitRequest !== 1'b0) begin
      errTotal++;
      stopTest;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    avXfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    avXfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic fetch(input logic lit, input logic [31:0] a, input logic hit, input int idx);
    @(posedge core_clk);
    cmd <= {1'b1, lit, a};
    @(posedge core_clk);
    cmd <= '0;
    #1;
    chk(fetchRsp.flashValid, 1'b1);
    chk(fetchRsp.flashAddr, a);
    chk(fetchRsp.protAddr, a);
    chk(fetchRsp.literal, lit);
    chk(fetchRsp.remapValid, hit);
    chk(usedAddr, hit ? remapOf(idx) : a);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic scnRegs;
    rdChk(fpbu_pkg::OFF_CTRL, 32'h00000260);
    wr(fpbu_pkg::OFF_CTRL, 32'hFFFFFFF0);
    rdChk(fpbu_pkg::OFF_CTRL, 32'h00000260);
    wr(fpbu_pkg::OFF_CTRL, 32'h00000001);
    fetch(1'b0, 32'h00000000, 1'b0, 0);
    fetch(1'b1, 32'h00000000, 1'b0, 0);
    wr(fpbu_pkg::OFF_CTRL, 32'h00000000);
    wr(6'h0C, 32'hFFFFFFFF);
    rdChk(6'h0C, 32'h00000000);
    rdChk(fpbu_pkg::OFF_COMP0, 32'h00000000);
    rdChk(fpbu_pkg::OFF_STATUS, 32'h00000000);
  endtask

  task automatic scnGlobalOff;
    wr(fpbu_pkg::OFF_COMP0, compVal(32'h00000100, 1'b0, 1'b1));
    wr(fpbu_pkg::OFF_REMAP, {3'h0, BASE, 5'h00});
    rdChk(fpbu_pkg::OFF_REMAP, {3'h0, BASE, 5'h00});
    fetch(1'b0, 32'h00000100, 1'b0, 0);
  endtask

  task automatic scnRemap;
    wr(fpbu_pkg::OFF_CTRL, 32'h00000001);
    for (int i = 0; i < fpbu_pkg::NUM_COMP; i++) begin
      wr(fpbu_pkg::OFF_COMP0 + 6'(4 * i), compVal(32'h00000200 + 32'(16 * i), 1'b0, 1'b1));
      fetch(i >= fpbu_pkg::NUM_INSN, 32'h00000200 + 32'(16 * i), 1'b1, i);
    end
    fetch(1'b0, 32'h20000200, 1'b0, 0);
    fetch(1'b0, 32'h00000270, 1'b0, 0);
  endtask

  // Two fetches on consecutive edges must each be answered the next cycle.
  task automatic scnBurst;
    @(posedge core_clk);
    cmd <= {1'b1, 1'b0, 32'h00000200};
    @(posedge core_clk);
    cmd <= {1'b1, 1'b0, 32'h00000210};
    #1;
    chk(fetchRsp.remapAddr, remapOf(0));
    @(posedge core_clk);
    cmd <= '0;
    #1;
    chk(fetchRsp.remapAddr, remapOf(1));
  endtask

  task automatic scnBkpt;
    wr(fpbu_pkg::OFF_COMP0 + 6'h08, compVal(32'h00000220, 1'b1, 1'b1));
    fetch(1'b0, 32'h00000220, 1'b0, 0);
    chk(fetchRsp.bkptValid, 1'b1);
    chk(fetchRsp.bkptInsn, fpbu_pkg::BKPT_INSN);
    rdChk(fpbu_pkg::OFF_STATUS, 32'h0000001A);
    wr(fpbu_pkg::OFF_COMP0 + 6'h18, compVal(32'h00000260, 1'b1, 1'b1));
    fetch(1'b1, 32'h00000260, 1'b1, 6);
    chk(fetchRsp.bkptValid, 1'b0);
  endtask

  task automatic scnPriority;
    wr(fpbu_pkg::OFF_COMP0 + 6'h0C, compVal(32'h00000210, 1'b0, 1'b1));
    fetch(1'b0, 32'h00000210, 1'b1, 1);
    rdChk(fpbu_pkg::OFF_STATUS, 32'h00000011);
  endtask

  task automatic scnMisc;
    fetch(1'b1, 32'h00000261, 1'b0, 0);
    wr(fpbu_pkg::OFF_COMP0 + 6'h1C, compVal(32'h00000270, 1'b0, 1'b0));
    fetch(1'b1, 32'h00000270, 1'b0, 0);
    wr(fpbu_pkg::OFF_CTRL, 32'h00000000);
    fetch(1'b0, 32'h00000200, 1'b0, 0);
  endtask

  initial begin
    errTotal     = 0;
    totalChecks  = 0;
    reset        = 1'b1;
    avAddress    = 6'h00;
    avRead       = 1'b0;
    avWrite      = 1'b0;
    avWriteData  = 32'h0;
    avByteEnable = 4'hF;
    cmd          = '0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    scnRegs;
    scnGlobalOff;
    scnRemap;
    scnBurst;
    scnBkpt;
    scnPriority;
    scnMisc;
    stopTest;
  end
endmodule
